// ==== rtl/flow_switch_pkg.sv ====
// Constants, register map and carrier types of the flow limit switch
// Functional notes
// [R1] Teach is taken only if the contact stays active 0.5 s to 2 s.
// [R2] Shorter or longer contact is discarded; all stored values stay unchanged.
// [R3] While the teach contact is active the LED flashes.
// [R4] Teach stores measured value plus signed factory offset.
// [R5] Teach updates the limit, or optionally the output end value.
// [R6] Minimum switch enters alarm when the value falls below the limit.
// [R7] Minimum switch returns when the value exceeds limit plus hysteresis.
// [R8] Maximum switch enters alarm when the value exceeds the limit.
// [R9] Maximum switch returns when the value drops below limit minus hysteresis.
// [R10] Configurable delay before entering the alarm state.
// [R11] Separate configurable delay before returning to the normal state.
// [R12] Outside teach the LED is lit in normal state, dark in alarm.
// [R13] Standard polarity: output high in normal state, low in alarm.
// [R14] Inverted polarity: output low in normal state, high in alarm.
// [R15] Power-on option holds the output normal for a set time after reset.
// [R16] Output function codes: minimum switch, maximum switch, frequency output.
// [R17] Hysteresis is 2 percent of full scale unless a special value is set.
// [R18] Outside teach the LED blinks when 10 percent beyond the switching value.
// [R19] A vanishing condition cancels a pending delay; timing restarts later.
package flow_switch_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TEACH_MIN_MS = 500;
    localparam int TEACH_MAX_MS = 2000;
    localparam int LED_BLINK_MS = 250;
    localparam int HYST_STD_PCT = 2;
    localparam int BEYOND_PCT = 10;
    localparam int VAL_W = 16;
    localparam int MS_W = 12;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LIMIT = 8'h04;
    localparam logic [7:0] OFS_HYST = 8'h08;
    localparam logic [7:0] OFS_ENTRY_DLY = 8'h0C;
    localparam logic [7:0] OFS_EXIT_DLY = 8'h10;
    localparam logic [7:0] OFS_PON_DLY = 8'h14;
    localparam logic [7:0] OFS_TEACH_OFS = 8'h18;
    localparam logic [7:0] OFS_END_VALUE = 8'h1C;
    localparam logic [7:0] OFS_FULL_SCALE = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
    localparam logic [7:0] OFS_MEAS = 8'h30;

    // Output function codes: 0 minimum, 1 maximum, 2 frequency
    typedef enum logic [1:0] {
        FUNC_MIN,
        FUNC_MAX,
        FUNC_FREQ
    } switch_func_type;

    // Control register, bits [5:0]
    typedef struct packed {
        logic hyst_special;
        logic teach_end;
        logic pon_en;
        logic invert;
        logic [1:0] func;
    } ctrl_type;
    localparam int CTRL_W = 6;

    // Event bits, shared by interrupt mask and interrupt status
    typedef struct packed {
        logic teach_bad;
        logic teach_ok;
        logic alarm_exit;
        logic alarm_entry;
    } events_type;
    localparam int EVT_W = 4;

    // Reset values
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [15:0] LIMIT_RST = 16'h8000;
    localparam logic [15:0] HYST_RST = 16'h0000;
    localparam logic [15:0] DLY_RST = 16'h0000;
    localparam logic [15:0] TEACH_OFS_RST = 16'h0000;
    localparam logic [15:0] END_VALUE_RST = 16'hFFFF;
    localparam logic [15:0] FULL_SCALE_RST = 16'hFFFF;
    localparam logic [3:0] EVT_RST = 4'h0;

endpackage

// ==== rtl/qual_timer.sv ====
// Millisecond delay timer that restarts whenever its condition drops
`timescale 1ns/1ps
`default_nettype none
module qual_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Control
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic [W-1:0] i_limit,
    // Result
    output logic o_done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic step;

    assign step = i_tick && (cnt_q < i_limit);
    // Condition gone clears the count
    assign cnt_d = !i_run ? '0 : (step ? cnt_q + W'(1) : cnt_q); // [R19]
    assign o_done = i_run && (cnt_q >= i_limit);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/flow_limit_switch_teach.sv ====
// Flow sensor limit switch with teach contact, delays and APB registers
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module flow_limit_switch_teach #(
    parameter int TICK_CYCLES = flow_switch_pkg::TICK_CYCLES,
    parameter int VAL_W = flow_switch_pkg::VAL_W
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Sensor side
    input wire logic [VAL_W-1:0] i_meas_value,
    input wire logic i_freq_wave,
    input wire logic i_teach_contact,
    // Outputs
    output logic o_switch_out,
    output logic o_led,
    output logic [VAL_W-1:0] o_end_value,
    output logic o_irq
);
    localparam int TCW = $clog2(TICK_CYCLES + 1);
    localparam int SW = VAL_W + 2;
    localparam int MS_W = flow_switch_pkg::MS_W;

    if (TICK_CYCLES < 2 || VAL_W < 8 || VAL_W > 16) begin : g_bad_params
        $error("flow_limit_switch_teach: unsupported parameter values");
    end

    typedef enum logic {
        ST_NORMAL,
        ST_ALARM
    } state_type;

    // Millisecond tick
    logic [TCW-1:0] tick_cnt_q;
    logic tick;
    assign tick = (tick_cnt_q == TCW'(TICK_CYCLES - 1));
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + TCW'(1);
        end
    end

    // Registers
    flow_switch_pkg::ctrl_type ctrl_q;
    logic [VAL_W-1:0] limit_q;
    logic [VAL_W-1:0] hyst_q;
    logic [15:0] entry_dly_q;
    logic [15:0] exit_dly_q;
    logic [15:0] pon_dly_q;
    logic [VAL_W-1:0] teach_ofs_q;
    logic [VAL_W-1:0] end_value_q;
    logic [VAL_W-1:0] full_scale_value_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;

    // Bus decode
    logic setup;
    logic wr;
    logic hit;
    logic wr_ctrl, wr_limit, wr_hyst, wr_entry, wr_exit, wr_pon;
    logic wr_ofs, wr_end, wr_fs, wr_stat, wr_mask;
    assign setup = i_psel && !i_penable;
    assign wr = i_psel && i_penable && i_pwrite;
    assign wr_ctrl = wr && (i_paddr == flow_switch_pkg::OFS_CTRL);
    assign wr_limit = wr && (i_paddr == flow_switch_pkg::OFS_LIMIT);
    assign wr_hyst = wr && (i_paddr == flow_switch_pkg::OFS_HYST);
    assign wr_entry = wr && (i_paddr == flow_switch_pkg::OFS_ENTRY_DLY);
    assign wr_exit = wr && (i_paddr == flow_switch_pkg::OFS_EXIT_DLY);
    assign wr_pon = wr && (i_paddr == flow_switch_pkg::OFS_PON_DLY);
    assign wr_ofs = wr && (i_paddr == flow_switch_pkg::OFS_TEACH_OFS);
    assign wr_end = wr && (i_paddr == flow_switch_pkg::OFS_END_VALUE);
    assign wr_fs = wr && (i_paddr == flow_switch_pkg::OFS_FULL_SCALE);
    assign wr_stat = wr && (i_paddr == flow_switch_pkg::OFS_IRQ_STAT);
    assign wr_mask = wr && (i_paddr == flow_switch_pkg::OFS_IRQ_MASK);

    // Teach contact synchroniser and duration counter
    logic cont_meta_q;
    logic cont_sync_q;
    logic cont_prev_q;
    logic [MS_W-1:0] teach_ms_q;
    logic teach_release;
    logic teach_ok;
    logic teach_bad;
    logic teach_limit;
    logic teach_end;
    logic [SW-1:0] teach_sum;
    logic [VAL_W-1:0] teach_val;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            cont_meta_q <= 1'b0;
            cont_sync_q <= 1'b0;
            cont_prev_q <= 1'b0;
        end else begin
            cont_meta_q <= i_teach_contact;
            cont_sync_q <= cont_meta_q;
            cont_prev_q <= cont_sync_q;
        end
    end

    // Count stops one past the longest valid time
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn || !cont_sync_q) begin
            teach_ms_q <= '0;
        end else if (tick && teach_ms_q <= MS_W'(flow_switch_pkg::TEACH_MAX_MS)) begin
            teach_ms_q <= teach_ms_q + MS_W'(1);
        end
    end

    assign teach_release = cont_prev_q && !cont_sync_q;
    assign teach_ok = teach_release // [R1]
        && teach_ms_q >= MS_W'(flow_switch_pkg::TEACH_MIN_MS)
        && teach_ms_q <= MS_W'(flow_switch_pkg::TEACH_MAX_MS);
    assign teach_bad = teach_release && !teach_ok; // [R2]
    assign teach_limit = teach_ok && !ctrl_q.teach_end; // [R5]
    assign teach_end = teach_ok && ctrl_q.teach_end; // [R5]

    // Measured value plus signed offset, clamped to the value range
    assign teach_sum = $signed({2'b00, i_meas_value})
        + $signed({{2{teach_ofs_q[VAL_W-1]}}, teach_ofs_q}); // [R4]
    assign teach_val = teach_sum[SW-1] ? '0
        : (teach_sum[SW-2] ? '1 : teach_sum[VAL_W-1:0]); // [R4]

    // Thresholds
    logic [31:0] fs_wide;
    logic [VAL_W-1:0] hyst_std;
    logic [VAL_W-1:0] hyst_eff;
    logic [VAL_W-1:0] beyond_step;
    logic signed [SW-1:0] meas_s, lim_s, hyst_s, beyond_s;
    logic min_mode, max_mode, limit_mode;
    logic enter_cond, leave_cond, beyond;

    assign fs_wide = 32'(full_scale_value_q);
    assign hyst_std = VAL_W'(fs_wide * flow_switch_pkg::HYST_STD_PCT / 100); // [R17]
    assign hyst_eff = ctrl_q.hyst_special ? hyst_q : hyst_std; // [R17]
    assign beyond_step = VAL_W'(fs_wide * flow_switch_pkg::BEYOND_PCT / 100);
    assign meas_s = $signed({2'b00, i_meas_value});
    assign lim_s = $signed({2'b00, limit_q});
    assign hyst_s = $signed({2'b00, hyst_eff});
    assign beyond_s = $signed({2'b00, beyond_step});

    assign min_mode = (ctrl_q.func == flow_switch_pkg::FUNC_MIN); // [R16]
    assign max_mode = (ctrl_q.func == flow_switch_pkg::FUNC_MAX); // [R16]
    assign limit_mode = min_mode || max_mode;
    assign enter_cond = min_mode ? (meas_s < lim_s) // [R6]
        : (max_mode && meas_s > lim_s); // [R8]
    assign leave_cond = min_mode ? (meas_s > lim_s + hyst_s) // [R7]
        : (max_mode && meas_s < lim_s - hyst_s); // [R9]
    assign beyond = min_mode ? (meas_s <= lim_s - beyond_s) // [R18]
        : (max_mode && meas_s >= lim_s + beyond_s); // [R18]

    // Delay timers
    state_type state_q;
    state_type state_d;
    logic entry_run, entry_done;
    logic exit_run, exit_done;
    logic pon_done;
    logic hold;

    assign hold = ctrl_q.pon_en && !pon_done; // [R15]
    assign entry_run = (state_q == ST_NORMAL) && enter_cond && !hold; // [R10]
    assign exit_run = (state_q == ST_ALARM) && leave_cond; // [R11]

    qual_timer #(.W(16)) u_entry_timer (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_run(entry_run),
        .i_tick(tick),
        .i_limit(entry_dly_q),
        .o_done(entry_done)
    );

    qual_timer #(.W(16)) u_exit_timer (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_run(exit_run),
        .i_tick(tick),
        .i_limit(exit_dly_q),
        .o_done(exit_done)
    );

    // Runs from reset release
    qual_timer #(.W(16)) u_pon_timer (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_run(1'b1),
        .i_tick(tick),
        .i_limit(pon_dly_q),
        .o_done(pon_done)
    );

    // Normal / alarm state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_NORMAL: begin
                if (entry_done) begin
                    state_d = ST_ALARM; // [R10]
                end
            end
            ST_ALARM: begin
                if (hold || !limit_mode || exit_done) begin
                    state_d = ST_NORMAL; // [R11]
                end
            end
            default: begin
                state_d = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            state_q <= ST_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // Blink timebase
    logic [MS_W-1:0] blink_ms_q;
    logic blink_q;
    logic blink_wrap;
    assign blink_wrap = tick && (blink_ms_q == MS_W'(flow_switch_pkg::LED_BLINK_MS - 1));
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            blink_ms_q <= '0;
            blink_q <= 1'b0;
        end else begin
            if (blink_wrap) begin
                blink_ms_q <= '0;
            end else if (tick) begin
                blink_ms_q <= blink_ms_q + MS_W'(1);
            end
            blink_q <= blink_q ^ blink_wrap;
        end
    end

    // Switching output and LED
    logic normal;
    logic sw_d;
    logic led_d;
    assign normal = (state_q == ST_NORMAL);
    assign sw_d = ctrl_q.func == flow_switch_pkg::FUNC_FREQ ? i_freq_wave // [R16]
        : (normal ^ ctrl_q.invert); // [R13] [R14]
    assign led_d = cont_sync_q ? blink_q // [R3]
        : (beyond ? blink_q : normal); // [R18] [R12]

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_switch_out <= 1'b1;
            o_led <= 1'b1;
        end else begin
            o_switch_out <= sw_d;
            o_led <= led_d;
        end
    end

    // Configuration registers; teach wins over a bus write
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            ctrl_q <= flow_switch_pkg::CTRL_RST;
            limit_q <= VAL_W'(flow_switch_pkg::LIMIT_RST);
            hyst_q <= VAL_W'(flow_switch_pkg::HYST_RST);
            entry_dly_q <= flow_switch_pkg::DLY_RST;
            exit_dly_q <= flow_switch_pkg::DLY_RST;
            pon_dly_q <= flow_switch_pkg::DLY_RST;
            teach_ofs_q <= VAL_W'(flow_switch_pkg::TEACH_OFS_RST);
            end_value_q <= VAL_W'(flow_switch_pkg::END_VALUE_RST);
            full_scale_value_q <= VAL_W'(flow_switch_pkg::FULL_SCALE_RST);
            irq_mask_q <= flow_switch_pkg::EVT_RST;
        end else begin
            if (wr_ctrl) ctrl_q <= i_pwdata[flow_switch_pkg::CTRL_W-1:0];
            if (teach_limit) begin
                limit_q <= teach_val; // [R4]
            end else if (wr_limit) begin
                limit_q <= i_pwdata[VAL_W-1:0];
            end
            if (teach_end) begin
                end_value_q <= teach_val; // [R5]
            end else if (wr_end) begin
                end_value_q <= i_pwdata[VAL_W-1:0];
            end
            if (wr_hyst) hyst_q <= i_pwdata[VAL_W-1:0];
            if (wr_entry) entry_dly_q <= i_pwdata[15:0];
            if (wr_exit) exit_dly_q <= i_pwdata[15:0];
            if (wr_pon) pon_dly_q <= i_pwdata[15:0];
            if (wr_ofs) teach_ofs_q <= i_pwdata[VAL_W-1:0];
            if (wr_fs) full_scale_value_q <= i_pwdata[VAL_W-1:0];
            if (wr_mask) irq_mask_q <= i_pwdata[flow_switch_pkg::EVT_W-1:0];
        end
    end

    // Sticky events, write one to clear, set wins
    flow_switch_pkg::events_type evt;
    logic [3:0] stat_clr;
    assign evt.alarm_entry = normal && (state_d == ST_ALARM);
    assign evt.alarm_exit = !normal && (state_d == ST_NORMAL);
    assign evt.teach_ok = teach_ok;
    assign evt.teach_bad = teach_bad;
    assign stat_clr = wr_stat ? i_pwdata[3:0] : 4'h0;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            irq_stat_q <= flow_switch_pkg::EVT_RST;
            o_irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~stat_clr) | evt;
            o_irq <= |(((irq_stat_q & ~stat_clr) | evt) & irq_mask_q);
        end
    end

    // Read path, sampled in the setup phase
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    assign status_word = {26'h000_0000, cont_sync_q, hold, beyond,
        o_led, o_switch_out, !normal};
    assign hit = (i_paddr <= flow_switch_pkg::OFS_MEAS) && (i_paddr[1:0] == 2'b00);

    always_comb begin
        case (i_paddr)
            flow_switch_pkg::OFS_CTRL: rd_mux = 32'(ctrl_q);
            flow_switch_pkg::OFS_LIMIT: rd_mux = 32'(limit_q);
            flow_switch_pkg::OFS_HYST: rd_mux = 32'(hyst_q);
            flow_switch_pkg::OFS_ENTRY_DLY: rd_mux = 32'(entry_dly_q);
            flow_switch_pkg::OFS_EXIT_DLY: rd_mux = 32'(exit_dly_q);
            flow_switch_pkg::OFS_PON_DLY: rd_mux = 32'(pon_dly_q);
            flow_switch_pkg::OFS_TEACH_OFS: rd_mux = 32'(teach_ofs_q);
            flow_switch_pkg::OFS_END_VALUE: rd_mux = 32'(end_value_q);
            flow_switch_pkg::OFS_FULL_SCALE: rd_mux = 32'(full_scale_value_q);
            flow_switch_pkg::OFS_STATUS: rd_mux = status_word;
            flow_switch_pkg::OFS_IRQ_STAT: rd_mux = 32'(irq_stat_q);
            flow_switch_pkg::OFS_IRQ_MASK: rd_mux = 32'(irq_mask_q);
            flow_switch_pkg::OFS_MEAS: rd_mux = 32'(i_meas_value);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_prdata <= 32'h0000_0000;
        end else if (setup) begin
            o_prdata <= rd_mux;
        end
    end

    assign o_pready = i_psel && i_penable;
    assign o_pslverr = i_psel && i_penable && !hit;
    assign o_end_value = end_value_q;
endmodule
`default_nettype wire

// ==== bench/line_receiver.sv ====
// Signal receiver model reading the switching output
`timescale 1ns/1ps
`default_nettype none
module line_receiver (
    // Clock and line
    input wire logic i_sys_clk,
    input wire logic i_line,
    // Wiring option
    input wire logic i_invert,
    // Decoded state
    output logic o_alarm
);
    // A low line reads as alarm unless the output is inverted
    always_ff @(posedge i_sys_clk) begin
        o_alarm <= i_line ^ !i_invert;
    end
endmodule
`default_nettype wire

// ==== bench/flow_switch_sva.sv ====
// Port-level assertions for the flow limit switch
`timescale 1ns/1ps
`default_nettype none
module flow_switch_sva #(
    parameter int TICK_CYCLES = 4,
    parameter int VAL_W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_teach_contact,
    input wire logic o_switch_out,
    input wire logic o_led,
    input wire logic [VAL_W-1:0] o_end_value,
    input wire logic o_irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    localparam int BLINK_LIM = 250 * TICK_CYCLES + 8;
    logic [31:0] stable_q;
    logic led_q;
    logic [3:0] since_fall_q;
    wire access = i_psel && i_penable;
    wire end_wr = access && i_pwrite && (i_paddr == 8'h1C);
    // LED run length while the contact is held
    always_ff @(posedge i_sys_clk) begin
        led_q <= o_led;
        if (!i_resetn || !i_teach_contact || (o_led != led_q)) stable_q <= '0;
        else stable_q <= stable_q + 32'h0000_0001;
        if (!i_resetn) since_fall_q <= 4'hF;
        else if (i_teach_contact) since_fall_q <= 4'h0;
        else if (since_fall_q != 4'hF) since_fall_q <= since_fall_q + 4'h1;
    end
    a_ready_zero_wait: assert property (disable iff (!i_resetn)
        o_pready == access) else $error("pready wrong");
    a_err_high_addr: assert property (disable iff (!i_resetn)
        access && (i_paddr > 8'h30) |-> o_pslverr) else $error("no error above map");
    a_err_unaligned: assert property (disable iff (!i_resetn)
        access && (i_paddr[1:0] != 2'b00) |-> o_pslverr) else $error("no error unaligned");
    a_no_err_mapped: assert property (disable iff (!i_resetn)
        access && (i_paddr <= 8'h30) && (i_paddr[1:0] == 2'b00) |-> !o_pslverr)
        else $error("error on mapped address");
    a_err_reads_zero: assert property (disable iff (!i_resetn)
        access && !i_pwrite && o_pslverr |-> o_prdata == 32'h0000_0000)
        else $error("refused read not zero");
    a_reset_state: assert property (!i_resetn |=> o_switch_out && o_led && !o_irq
        && (o_end_value == '1)) else $error("reset state wrong");
    a_teach_flash: assert property (disable iff (!i_resetn)
        stable_q < BLINK_LIM) else $error("LED not flashing during teach");
    a_end_value_cause: assert property (disable iff (!i_resetn)
        $changed(o_end_value) |-> $past(end_wr) || (since_fall_q inside {[4'h1:4'h8]}))
        else $error("end value changed without cause");
endmodule
bind flow_limit_switch_teach flow_switch_sva #(
    .TICK_CYCLES(TICK_CYCLES),
    .VAL_W(VAL_W)
) u_sva (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_teach_contact(i_teach_contact),
    .o_switch_out(o_switch_out),
    .o_led(o_led),
    .o_end_value(o_end_value),
    .o_irq(o_irq)
);
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the flow limit switch
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int TICK = 4;
    typedef struct packed {
        logic [7:0] a;
        logic [15:0] r;
        logic [15:0] w;
        logic [15:0] e;
        logic err;
    } reg_row_type;
    typedef struct packed {
        logic [11:0] ticks;
        logic [15:0] m;
        logic [15:0] ctrl;
        logic [15:0] lim;
        logic [15:0] endv;
        logic [15:0] stat;
    } teach_row_type;
    reg_row_type regs [14] = '{
        '{8'h00, 16'h0000, 16'h003F, 16'h003F, 1'b0},
        '{8'h04, 16'h8000, 16'h1234, 16'h1234, 1'b0},
        '{8'h08, 16'h0000, 16'h0055, 16'h0055, 1'b0},
        '{8'h0C, 16'h0000, 16'h0123, 16'h0123, 1'b0},
        '{8'h10, 16'h0000, 16'h0234, 16'h0234, 1'b0},
        '{8'h14, 16'h0000, 16'h0345, 16'h0345, 1'b0},
        '{8'h18, 16'h0000, 16'h7F00, 16'h7F00, 1'b0},
        '{8'h1C, 16'hFFFF, 16'h1111, 16'h1111, 1'b0},
        '{8'h20, 16'hFFFF, 16'h2222, 16'h2222, 1'b0},
        '{8'h2C, 16'h0000, 16'h000F, 16'h000F, 1'b0},
        '{8'h28, 16'h0000, 16'h000F, 16'h0000, 1'b0},
        '{8'h30, 16'h9ABC, 16'h0000, 16'h9ABC, 1'b0},
        '{8'h34, 16'h0000, 16'h0001, 16'h0000, 1'b1},
        '{8'h02, 16'h0000, 16'h0001, 16'h0000, 1'b1}};
    // Offset is -256; limit starts at its reset value
    teach_row_type teach [6] = '{
        '{12'd497, 16'h3000, 16'h0003, 16'h8000, 16'hFFFF, 16'h0008},
        '{12'd502, 16'h4000, 16'h0003, 16'h3F00, 16'hFFFF, 16'h0004},
        '{12'd1998, 16'h5000, 16'h0003, 16'h4F00, 16'hFFFF, 16'h0004},
        '{12'd2003, 16'h6000, 16'h0003, 16'h4F00, 16'hFFFF, 16'h0008},
        '{12'd1000, 16'h0080, 16'h0003, 16'h0000, 16'hFFFF, 16'h0004},
        '{12'd1000, 16'h7000, 16'h0013, 16'h0000, 16'h6F00, 16'h0004}};
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [15:0] meas = 16'h9ABC;
    logic fwave = 1'b0, contact = 1'b0, inv = 1'b0;
    logic [31:0] rd;
    logic er;
    wire [31:0] prdata;
    wire [15:0] endv;
    wire pready, pslverr, sw, led, irq, rx_alarm;
    int fails = 0, check_count = 0, cyc = 0;
    flow_limit_switch_teach #(.TICK_CYCLES(TICK), .VAL_W(16)) dut (
        .i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_meas_value(meas),
        .i_freq_wave(fwave), .i_teach_contact(contact), .o_switch_out(sw),
        .o_led(led), .o_end_value(endv), .o_irq(irq));
    line_receiver rx (.i_sys_clk(clk), .i_line(sw), .i_invert(inv), .o_alarm(rx_alarm));
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
    endtask
    task automatic settle(input logic [15:0] m, input int n);
        meas <= m;
        repeat (n) @(posedge clk);
    endtask
    initial begin
        do_reset();
        foreach (regs[i]) begin
            apb(1'b0, regs[i].a, 16'h0000);
            check("register reset", rd, regs[i].r);
            apb(1'b1, regs[i].a, regs[i].w);
            check("write error", er, regs[i].err);
            apb(1'b0, regs[i].a, 16'h0000);
            check("register readback", rd, regs[i].e);
        end
        $display("registers test done");
        do_reset();
        check("switch in reset", sw, 1'b1);
        check("led in reset", led, 1'b1);
        check("end value in reset", endv, 16'hFFFF);
        meas <= 16'h1000;
        apb(1'b1, 8'h14, 16'h00C8);
        apb(1'b1, 8'h00, 16'h0008);
        repeat (300) @(posedge clk);
        check("held normal", rx_alarm, 1'b0);
        repeat (600) @(posedge clk);
        check("alarm after hold", rx_alarm, 1'b1);
        apb(1'b0, 8'h24, 16'h0000);
        check("beyond flag", rd[3], 1'b1);
        $display("power-on test done");
        do_reset();
        meas <= 16'h9000;
        apb(1'b1, 8'h0C, 16'h0003);
        apb(1'b1, 8'h10, 16'h0002);
        apb(1'b1, 8'h2C, 16'h0001);
        settle(16'h7FFF, 6);
        settle(16'h9000, 40);
        check("short dip", rx_alarm, 1'b0);
        settle(16'h7FFF, 6);
        check("entry delayed", rx_alarm, 1'b0);
        repeat (30) @(posedge clk);
        check("min alarm", rx_alarm, 1'b1);
        check("led dark", led, 1'b0);
        check("irq raised", irq, 1'b1);
        apb(1'b1, 8'h28, 16'h0001);
        repeat (2) @(posedge clk);
        check("irq cleared", irq, 1'b0);
        settle(16'h851E, 40);
        check("min at hysteresis", rx_alarm, 1'b1);
        settle(16'h851F, 30);
        check("min return", rx_alarm, 1'b0);
        check("led lit", led, 1'b1);
        check("irq masked", irq, 1'b0);
        apb(1'b0, 8'h28, 16'h0000);
        check("exit event", rd, 32'h0000_0002);
        $display("minimum switch test done");
        apb(1'b1, 8'h08, 16'h0010);
        inv <= 1'b1;
        apb(1'b1, 8'h00, 16'h0025);
        settle(16'h8000, 40);
        check("max at limit", rx_alarm, 1'b0);
        settle(16'h8001, 30);
        check("max alarm", rx_alarm, 1'b1);
        check("inverted high", sw, 1'b1);
        settle(16'h7FF0, 40);
        check("special hysteresis", rx_alarm, 1'b1);
        settle(16'h7FEF, 30);
        check("max return", rx_alarm, 1'b0);
        check("inverted low", sw, 1'b0);
        $display("maximum switch test done");
        inv <= 1'b0;
        apb(1'b1, 8'h00, 16'h0002);
        for (int i = 0; i < 6; i++) begin
            fwave <= i[0];
            repeat (2) @(posedge clk);
            check("frequency out", sw, i[0]);
        end
        $display("frequency test done");
        apb(1'b1, 8'h18, 16'hFF00);
        apb(1'b1, 8'h28, 16'h000F);
        foreach (teach[i]) begin
            apb(1'b1, 8'h00, teach[i].ctrl);
            meas <= teach[i].m;
            contact <= 1'b1;
            repeat (teach[i].ticks * TICK) @(posedge clk);
            contact <= 1'b0;
            repeat (12) @(posedge clk);
            apb(1'b0, 8'h04, 16'h0000);
            check("taught limit", rd, teach[i].lim);
            check("taught end value", endv, teach[i].endv);
            apb(1'b0, 8'h28, 16'h0000);
            check("teach event", rd, teach[i].stat);
            apb(1'b1, 8'h28, 16'h000F);
        end
        $display("teach test done");
        report_and_stop();
    end
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
endmodule
`default_nettype wire
